// File: hw/fia_aggregator.sv
`timescale 1ns/1ps
`include "fia_regs.svh"
module fia_aggregator #(
	parameter int NUM_LANES = `FIA_NUM_LANES
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [NUM_LANES-1:0] fault_feedback_lanes,
	input  wire logic [NUM_LANES-1:0] laneMask,
	input  wire logic                 conn_a_fault_in_n,
	input  wire logic                 conn_b_fault_in_n,
	input  wire logic                 conn_c_fault_in_n,
	input  wire logic                 conn_d_fault_in_n,
	input  wire logic                 connFaultEnable,
	input  wire logic                 elecInterlockIn_n,
	input  wire logic                 opticalRxLight,
	input  wire logic                 fibreFaultIn,
	input  wire logic                 faultClear,
	output logic                      pwmBlock,
	output logic [NUM_LANES-1:0]      laneLevel,
	output logic                      interlock_fault_out_n,
	output logic [`FIA_NUM_CONN-1:0]  connFaultOut_n,
	output logic                      opticalEmitterOn,
	output logic                      fibreFaultOut,
	output logic                      faultTripped,
	output fia_pkg::fia_src_t         faultCause
);
	localparam int LANE_CYC = `FIA_LANE_CYC;
	localparam int ELEC_CYC = `FIA_ELEC_CYC;
	localparam int OPT_CYC  = `FIA_OPT_CYC;
	localparam int LINK_CYC = `FIA_LINK_CYC;

	// ****************************************************************
	// input sampling
	// ****************************************************************
	logic [NUM_LANES-1:0]     laneQ_q;
	logic [NUM_LANES-1:0]     maskQ_q;
	logic [`FIA_NUM_CONN-1:0] connQ_q;
	logic                     connEn_q;
	logic                     elecQ_q;
	logic                     lightQ_q;
	logic                     linkQ_q;
	fia_pkg::fia_src_t        srcVec;
	fia_pkg::fia_state_t      state_q;
	fia_pkg::fia_state_t      state_d;
	fia_pkg::fia_src_t        cause_d;
	logic                     sysFault;

	// one flop on every pin but faultClear; the whole path is two edges, under 50 ns
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			laneQ_q  <= `FIA_LANE_RST;
			maskQ_q  <= `FIA_LANE_RST;
			connQ_q  <= '1;
			elecQ_q  <= 1'b1;
			lightQ_q <= 1'b1;
			linkQ_q  <= 1'b0;
		end else begin
			laneQ_q  <= fault_feedback_lanes;
			maskQ_q  <= laneMask;
			connQ_q  <= {conn_d_fault_in_n, conn_c_fault_in_n,
			             conn_b_fault_in_n, conn_a_fault_in_n};
			elecQ_q  <= elecInterlockIn_n;
			lightQ_q <= opticalRxLight;
			linkQ_q  <= fibreFaultIn;
		end
	end

	// connector flags stay ignored from reset until enabled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			connEn_q <= `FIA_CONN_EN_RST; // RULE10
		end else begin
			connEn_q <= connFaultEnable;
		end
	end

	fia_source_merge #(
		.NUM_LANES (NUM_LANES),
		.NUM_CONN  (`FIA_NUM_CONN)
	) u_merge (
		.laneQ   (laneQ_q),
		.maskQ   (maskQ_q),
		.connQ_n (connQ_q),
		.connEnQ (connEn_q),
		.elecQ_n (elecQ_q),
		.lightQ  (lightQ_q),
		.linkQ   (linkQ_q),
		.srcVec  (srcVec)
	);

	// ****************************************************************
	// fault manager state
	// ****************************************************************
	// a live source keeps the trip even when clear arrives with it
	always_comb begin
		state_d = state_q;
		case (state_q)
			fia_pkg::FIA_RUN: begin
				if (|srcVec) begin
					state_d = fia_pkg::FIA_TRIP;
				end
			end
			fia_pkg::FIA_TRIP: begin
				if (faultClear && !(|srcVec)) begin
					state_d = fia_pkg::FIA_RUN;
				end
			end
			default: begin
				state_d = fia_pkg::FIA_TRIP;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= fia_pkg::FIA_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// any live source or a held trip is the system fault
	assign sysFault = (|srcVec) | (state_q != fia_pkg::FIA_RUN); // RULE12

	// sticky cause record: set wins over clear
	always_comb begin
		cause_d = faultClear ? `FIA_CAUSE_RST : faultCause;
		cause_d = cause_d | srcVec;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			faultCause <= `FIA_CAUSE_RST;
		end else begin
			faultCause <= cause_d;
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	// block and announce from one shared next value so they never skew
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwmBlock              <= 1'b0;
			interlock_fault_out_n <= 1'b1;
			connFaultOut_n        <= '1;
			opticalEmitterOn      <= 1'b1;
			fibreFaultOut         <= 1'b0;
			faultTripped          <= 1'b0;
		end else begin
			pwmBlock              <= sysFault; // RULE3 RULE6 RULE12
			interlock_fault_out_n <= ~sysFault; // RULE4
			connFaultOut_n        <= {`FIA_NUM_CONN{~sysFault}}; // RULE9
			opticalEmitterOn      <= ~sysFault; // RULE5
			fibreFaultOut         <= sysFault; // RULE7
			faultTripped          <= (state_d == fia_pkg::FIA_TRIP);
		end
	end

	// lane levels readable regardless of mask or trip
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			laneLevel <= `FIA_LANE_RST;
		end else begin
			laneLevel <= laneQ_q; // RULE2
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_laneFault;
		|(fault_feedback_lanes & laneMask);
	endsequence

	// pin seen at one edge must show as a block no later than three edges on
	a_lane_block: assert property ( // RULE3 RULE1 RULE11
		s_laneFault |-> ##[1:LANE_CYC] pwmBlock)
		else $error("lane fault did not block outputs in time");

	a_lane_read: assert property ( // RULE2
		##2 laneLevel == $past(fault_feedback_lanes, 2))
		else $error("lane level readback is wrong");

	a_elec_block: assert property ( // RULE6 RULE4
		!elecInterlockIn_n |-> ##[1:ELEC_CYC] pwmBlock)
		else $error("electrical interlock did not block in time");

	a_opt_block: assert property ( // RULE6 RULE5
		!opticalRxLight |-> ##[1:OPT_CYC] (pwmBlock && !opticalEmitterOn))
		else $error("optical interlock did not block in time");

	a_link_fwd: assert property ( // RULE7
		fibreFaultIn |-> ##[1:LINK_CYC] fibreFaultOut)
		else $error("fault not forwarded on fibre link");

	a_conn_copy: assert property ( // RULE9
		connFaultOut_n == {`FIA_NUM_CONN{interlock_fault_out_n}})
		else $error("connector fault output differs from interlock out");

	a_conn_gate: assert property ( // RULE10 RULE8
		!connEn_q |-> !srcVec[`FIA_SRC_CONN])
		else $error("connector flag acted while disabled");

	// any one low flag, once enabled, trips and records the merged source
	a_conn_trip: assert property ( // RULE8 RULE10
		(connFaultEnable && !(&{conn_d_fault_in_n, conn_c_fault_in_n,
		                        conn_b_fault_in_n, conn_a_fault_in_n}))
		|-> ##2 (pwmBlock && faultCause[`FIA_SRC_CONN]))
		else $error("enabled connector flag did not trip");

	a_out_agree: assert property ( // RULE12 RULE4
		pwmBlock |-> (!interlock_fault_out_n && fibreFaultOut
		              && !opticalEmitterOn))
		else $error("block and interlock outputs disagree");

	a_trip_cause: assert property ( // RULE12
		$rose(pwmBlock) |-> ($past(srcVec) != '0))
		else $error("outputs blocked with no enabled source");

	a_mask_quiet: assert property ( // RULE11
		(srcVec[`FIA_SRC_LANE]) |-> |(laneQ_q & maskQ_q))
		else $error("masked lane raised a fault");
endmodule

// File: hw/fia_pkg.sv
`include "fia_regs.svh"
package fia_pkg;
	// one-hot fault manager states
	typedef enum logic [1:0] {
		FIA_RUN  = 2'b01,
		FIA_TRIP = 2'b10
	} fia_state_t;

	typedef logic [`FIA_NUM_SRC-1:0] fia_src_t;
endpackage

// File: hw/fia_regs.svh
`ifndef FIA_REGS_SVH
`define FIA_REGS_SVH
// Functional notes
// RULE1 - sixteen fault feedback lanes each feed the fault manager as fault sources
// RULE2 - current level of every fault lane is readable as a plain input value
// RULE3 - a lane fault blocks all modulated outputs within 60 ns at most
// RULE4 - interlock is two-way: output announces own fault, input triggers a fault
// RULE5 - optical: light means no fault; emitter off on fault, dark input is fault
// RULE6 - block outputs within 78 ns after optical, 50 ns after electrical fault
// RULE7 - fault propagates over the unit-to-unit fibre link, about 0.25 us
// RULE8 - four connector fault flags merge into one source before the manager
// RULE9 - each connector fault output is an exact copy of the interlock output
// RULE10 - connector fault flags are active low and ignored after reset until enabled
// RULE11 - per-lane enable mask; masked lanes never raise a fault
// RULE12 - all enabled sources OR into one system fault driving block and outputs

// ****************************************************************
// clock and timing
// ****************************************************************
`define FIA_CLK_PERIOD_NS 20
`define FIA_LANE_MAX_NS   60
`define FIA_ELEC_MAX_NS   50
`define FIA_OPT_MAX_NS    78
`define FIA_LINK_TYP_NS   250
// longest times, and the typical link time, round down to whole cycles
`define FIA_LANE_CYC (`FIA_LANE_MAX_NS / `FIA_CLK_PERIOD_NS)
`define FIA_ELEC_CYC (`FIA_ELEC_MAX_NS / `FIA_CLK_PERIOD_NS)
`define FIA_OPT_CYC  (`FIA_OPT_MAX_NS / `FIA_CLK_PERIOD_NS)
`define FIA_LINK_CYC (`FIA_LINK_TYP_NS / `FIA_CLK_PERIOD_NS)

// ****************************************************************
// sizes, source vector positions, reset values
// ****************************************************************
`define FIA_NUM_LANES 16
`define FIA_NUM_CONN  4
`define FIA_NUM_SRC   5
`define FIA_SRC_LANE  0
`define FIA_SRC_CONN  1
`define FIA_SRC_ELEC  2
`define FIA_SRC_OPT   3
`define FIA_SRC_LINK  4
`define FIA_CONN_EN_RST 1'b0
`define FIA_CAUSE_RST   5'h00
`define FIA_LANE_RST    16'h0000
`endif

// File: hw/fia_source_merge.sv
`timescale 1ns/1ps
`include "fia_regs.svh"
module fia_source_merge #(
	parameter int NUM_LANES = `FIA_NUM_LANES,
	parameter int NUM_CONN  = `FIA_NUM_CONN
) (
	input  wire logic [NUM_LANES-1:0] laneQ,
	input  wire logic [NUM_LANES-1:0] maskQ,
	input  wire logic [NUM_CONN-1:0]  connQ_n,
	input  wire logic                 connEnQ,
	input  wire logic                 elecQ_n,
	input  wire logic                 lightQ,
	input  wire logic                 linkQ,
	output fia_pkg::fia_src_t         srcVec
);
	// any line of an active-low group pulled low
	function automatic logic fiaAnyLow(input logic [NUM_CONN-1:0] v);
		fiaAnyLow = ~&v;
	endfunction

	logic [NUM_LANES-1:0] laneHit;

	// masked lanes are cut before the OR so they can never trip
	genvar i;
	generate
		for (i = 0; i < NUM_LANES; i++) begin : g_lane
			assign laneHit[i] = laneQ[i] & maskQ[i]; // RULE11 RULE1
		end
	endgenerate

	// one bit per source class
	assign srcVec[`FIA_SRC_LANE] = |laneHit; // RULE1
	assign srcVec[`FIA_SRC_CONN] = connEnQ & fiaAnyLow(connQ_n); // RULE8 RULE10
	assign srcVec[`FIA_SRC_ELEC] = ~elecQ_n; // RULE4
	assign srcVec[`FIA_SRC_OPT]  = ~lightQ; // RULE5
	assign srcVec[`FIA_SRC_LINK] = linkQ; // RULE7
endmodule

// File: tb/fia_power_stage.sv
`timescale 1ns/1ps
// ****************************************************************
// far side: power stage, interlock partners and networked units
// ****************************************************************
module fia_power_stage (
	input  wire logic       elecCmd,
	input  wire logic       darkCmd,
	input  wire logic       remoteCmd,
	input  wire logic [3:0] connCmd,
	output logic            elecInterlockIn_n,
	output logic            opticalRxLight,
	output logic            fibreFaultIn,
	output logic [3:0]      connIn_n
);
	// interlock line pulled low by the partner on its own fault
	assign elecInterlockIn_n = ~elecCmd;
	// light kept on unless the partner reports a fault
	assign opticalRxLight = ~darkCmd;
	// remote unit fault arrives as a plain level
	assign fibreFaultIn = remoteCmd;
	// connector flags idle high through pull-ups, pulled low on fault
	assign connIn_n = ~connCmd;
endmodule

// File: tb/test_fault_interlock_aggregator.sv
`timescale 1ns/1ps
`include "fia_regs.svh"
module test_fault_interlock_aggregator;
	logic              clk;
	logic              rst_n;
	logic [15:0]       lanes;
	logic [15:0]       laneMask;
	logic              connFaultEnable;
	logic              faultClear;
	logic              elecCmd;
	logic              darkCmd;
	logic              remoteCmd;
	logic [3:0]        connCmd;
	logic              elecIn_n;
	logic              rxLight;
	logic              fibreIn;
	logic [3:0]        connIn_n;
	logic              pwmBlock;
	logic [15:0]       laneLevel;
	logic              lockOut_n;
	logic [3:0]        connOut_n;
	logic              emitterOn;
	logic              fibreOut;
	logic              tripped;
	fia_pkg::fia_src_t cause;
	int                mismatches;
	int                total_checks;
	int                cycles;

	fia_aggregator fia_aggregator_i (.clk(clk), .rst_n(rst_n),
		.fault_feedback_lanes(lanes), .laneMask(laneMask),
		.conn_a_fault_in_n(connIn_n[0]), .conn_b_fault_in_n(connIn_n[1]),
		.conn_c_fault_in_n(connIn_n[2]), .conn_d_fault_in_n(connIn_n[3]),
		.connFaultEnable(connFaultEnable), .elecInterlockIn_n(elecIn_n),
		.opticalRxLight(rxLight), .fibreFaultIn(fibreIn),
		.faultClear(faultClear), .pwmBlock(pwmBlock), .laneLevel(laneLevel),
		.interlock_fault_out_n(lockOut_n), .connFaultOut_n(connOut_n),
		.opticalEmitterOn(emitterOn), .fibreFaultOut(fibreOut),
		.faultTripped(tripped), .faultCause(cause));

	fia_power_stage fia_power_stage_i (.elecCmd(elecCmd), .darkCmd(darkCmd),
		.remoteCmd(remoteCmd), .connCmd(connCmd),
		.elecInterlockIn_n(elecIn_n), .opticalRxLight(rxLight),
		.fibreFaultIn(fibreIn), .connIn_n(connIn_n));

	// ****************************************************************
	// clock, timeout, reporting
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// a hang is cut short well beyond the expected run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen, input logic [31:0] ex);
		total_checks++;
		if (seen !== ex) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
		end
	endtask

	// every fault output follows one system fault, idle otherwise
	task expect_state(input string what, input logic trip,
		input fia_pkg::fia_src_t ex);
		chk(what,
			{18'h0, pwmBlock, lockOut_n, connOut_n, emitterOn, fibreOut,
			tripped, cause},
			trip ? {18'h0, 9'h103, ex} : {18'h0, 9'h0FC, 5'h00});
	endtask

	// two edges from pin change to outputs, per the hand-over timing
	task settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// sources must already be gone; clear is taken once they are sampled
	task clear_trip();
		repeat (3) @(posedge clk);
		faultClear <= 1'b1;
		@(posedge clk);
		faultClear <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset();
		expect_state("reset", 1'b0, 5'h00);
		chk("reset level", laneLevel, 16'h0000);
		$display("test reset done");
	endtask

	task t_lane();
		@(posedge clk);
		lanes <= 16'h8001;
		settle();
		expect_state("lane trip", 1'b1, 5'h01);
		chk("lane level", laneLevel, 16'h8001);
		@(posedge clk);
		faultClear <= 1'b1;
		@(posedge clk);
		faultClear <= 1'b0;
		settle();
		// clear is refused while the lane stays live
		expect_state("clear refused", 1'b1, 5'h01);
		@(posedge clk);
		lanes <= 16'h0000;
		clear_trip();
		expect_state("lane cleared", 1'b0, 5'h00);
		$display("test lane done");
	endtask

	task t_mask();
		@(posedge clk);
		laneMask <= 16'h7FFE;
		lanes <= 16'h8001;
		repeat (3) settle();
		expect_state("masked lanes", 1'b0, 5'h00);
		chk("masked level", laneLevel, 16'h8001);
		@(posedge clk);
		lanes <= 16'h0000;
		laneMask <= 16'hFFFF;
		$display("test mask done");
	endtask

	task t_conn();
		@(posedge clk);
		connCmd <= 4'h4;
		repeat (3) settle();
		expect_state("conn disabled", 1'b0, 5'h00);
		@(posedge clk);
		connFaultEnable <= 1'b1;
		settle();
		expect_state("conn trip", 1'b1, 5'h02);
		chk("conn copies", {28'h0, connOut_n}, {28'h0, {4{lockOut_n}}});
		@(posedge clk);
		connCmd <= 4'h0;
		clear_trip();
		expect_state("conn cleared", 1'b0, 5'h00);
		$display("test conn done");
	endtask

	// electrical, optical and fibre sources in turn
	task t_external();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			{remoteCmd, darkCmd, elecCmd} <= 3'h1 << i;
			settle();
			expect_state("external trip", 1'b1, 5'h04 << i);
			@(posedge clk);
			{remoteCmd, darkCmd, elecCmd} <= 3'h0;
			clear_trip();
			expect_state("external cleared", 1'b0, 5'h00);
		end
		$display("test external done");
	endtask

	initial begin
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		rst_n = 1'b0;
		lanes = 16'h0000;
		laneMask = 16'hFFFF;
		connFaultEnable = 1'b0;
		faultClear = 1'b0;
		elecCmd = 1'b0;
		darkCmd = 1'b0;
		remoteCmd = 1'b0;
		connCmd = 4'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_reset();
		t_lane();
		t_mask();
		t_conn();
		t_external();
		print_verdict();
	end
endmodule
